// File: logic/clock_guard_and_reset_status.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "clock_guard_map.svh"

// How it works
// - filter drops main clock edges arriving faster than the allowed rate.
// - filtering ends by itself once main clock edges are slow enough again.
// - no valid main edge for one safe period switches to backup oscillator.
// - valid main clock edges again switch the source back automatically.
// - hardware selecting backup sets the safe-clock-active flag.
// - interrupt only when enable set and CPU global mask clear; the irq output ignores both.
// - in WAIT the guard runs normally and its interrupt wakes the device.
// - HALT freezes status register and stops the whole guard.
// - leaving HALT by interrupt keeps config; by reset, restarts from reset values.
// - bit 4 set by undervoltage reset, cleared by writing zero.
// - undervoltage flag survives later external or watchdog resets.
// - bit 2 is read/write guard interrupt enable, inert if guard option off.
// - bit 1 shows backup selected; clears on read after recovery; zero if option off.
// - bit 0 set on watchdog reset, cleared by zero write or undervoltage reset.
// - flag pair encodes last reset: external 00, watchdog 01, undervoltage 1x; here an external reset leaves the pair unchanged.
// - CPU clock made by prescaler steered by two divider bits and slow bit.
// - clock-out enable drives CPU clock onto its dedicated pin.
// - slow mode divides by 4, 8, 16 or 32; normal mode by 2.
module clock_guard_and_reset_status
(
    // bus clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // oscillator inputs and system state (asynchronous pins)
    input  wire logic        main_osc,
    input  wire logic        guard_option_en,
    input  wire logic        cpu_irq_masked,
    input  wire logic        halt_mode,
    input  wire logic        wait_mode,
    // reset cause pulses from the reset sequencer, same clock
    input  wire logic        undervoltage_reset,
    input  wire logic        watchdog_reset,
    input  wire logic        external_reset,
    // clock outputs and requests
    output logic             cpu_clk,
    output logic             clk_out_pin,
    output logic             safe_clock_select,
    output logic             guard_irq_req,
    output logic             wake_req,
    output logic             irq
);

    // ========================================
    // input synchronisers
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end
        else
        begin
            sync1_q <= {main_osc, guard_option_en, cpu_irq_masked, halt_mode, wait_mode};
            sync2_q <= sync1_q;
        end
    end
    logic osc_s;
    logic opt_s;
    logic imask_s;
    logic halt_s;
    logic wait_s;
    assign osc_s   = sync2_q[4];
    assign opt_s   = sync2_q[3];
    assign imask_s = sync2_q[2];
    assign halt_s  = sync2_q[1];
    assign wait_s  = sync2_q[0];

    // ========================================
    // clock filter and loss detector
    logic       osc_prev_q;
    logic [7:0] half_cnt_q;
    logic [7:0] loss_cnt_q;
    logic       good_edge;
    logic       osc_edge;
    clock_guard_pkg::clk_src_t src_q;

    assign osc_edge  = osc_s ^ osc_prev_q;
    // edges closer than the minimum half period are spikes and are dropped
    // the counter reads one less than the edge spacing when the next edge lands
    assign good_edge = osc_edge && (half_cnt_q >= 8'(`MIN_HALF_CYC - 1));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_prev_q <= 1'b0;
            half_cnt_q <= 8'h00;
        end
        else if (!halt_s)
        begin
            osc_prev_q <= osc_s;
            if (osc_edge)
                half_cnt_q <= 8'h00;
            else if (half_cnt_q != 8'hFF)
                half_cnt_q <= half_cnt_q + 8'h01;
        end
    end

    // wait mode leaves the guard untouched; only halt or the option off stops it
    logic guard_run;
    assign guard_run = opt_s && !halt_s;

    // a device reset restarts the guard from its reset state, even in halt
    logic guard_restart;
    assign guard_restart = undervoltage_reset || watchdog_reset || external_reset;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            loss_cnt_q <= 8'h00;
            src_q      <= clock_guard_pkg::SRC_MAIN;
        end
        else if (!opt_s || guard_restart)
        begin
            loss_cnt_q <= 8'h00;
            src_q      <= clock_guard_pkg::SRC_MAIN;
        end
        else if (guard_run)
        begin
            if (good_edge)
            begin
                loss_cnt_q <= 8'h00;
                src_q      <= clock_guard_pkg::SRC_MAIN;
            end
            else if (loss_cnt_q >= 8'(`SAFE_PERIOD_CYC - 1))
                src_q      <= clock_guard_pkg::SRC_SAFE;
            else
                loss_cnt_q <= loss_cnt_q + 8'h01;
        end
    end

    // ========================================
    // ahb-lite slave
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [11:0] addr_q;
    logic        accept;
    assign accept = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end
        else
        begin
            wr_pend_q <= accept && hwrite;
            rd_pend_q <= accept && !hwrite;
            if (accept)
                addr_q <= haddr;
        end
    end

    logic crs_wr;
    logic crs_rd;
    assign crs_wr = wr_pend_q && (addr_q == `CRS_ADDR);
    assign crs_rd = accept && !hwrite && (haddr == `CRS_ADDR);

    // write data of the pending transfer, picked bit by bit
    function automatic logic hwrite_bit(input int idx);
        hwrite_bit = hwdata[idx];
    endfunction

    // ========================================
    // clock_reset_status
    logic uvr_q;
    logic wdr_q;
    logic ie_q;
    logic safe_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            uvr_q  <= 1'b0;
            wdr_q  <= 1'b0;
            ie_q   <= 1'b0;
            safe_q <= 1'b0;
        end
        else
        begin
            // undervoltage beats all; external/watchdog leave it alone
            if (undervoltage_reset)
                uvr_q <= 1'b1;
            else if (crs_wr && !hwrite_bit(`CRS_UVR_BIT) && !halt_s)
                uvr_q <= 1'b0;
            if (undervoltage_reset)
                wdr_q <= 1'b0;
            else if (watchdog_reset)
                wdr_q <= 1'b1;
            else if (crs_wr && !hwrite_bit(`CRS_WDR_BIT) && !halt_s)
                wdr_q <= 1'b0;
            // any reset of the guard restarts its config
            if (guard_restart)
                ie_q <= 1'b0;
            else if (crs_wr && !halt_s)
                ie_q <= hwrite_bit(`CRS_IE_BIT);
            if (!opt_s || guard_restart)
                safe_q <= 1'b0;
            else if (halt_s)
                safe_q <= safe_q;
            else if (src_q == clock_guard_pkg::SRC_SAFE)
                safe_q <= 1'b1;
            else if (crs_rd)
                safe_q <= 1'b0;
        end
    end

    // ========================================
    // misc_control_one and prescaler
    clock_guard_pkg::misc_t misc_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            misc_q <= '0;
        else if (wr_pend_q && (addr_q == `MISC_ADDR))
            misc_q <= hwdata[3:0];
    end

    logic [4:0] div_cnt_q;
    logic [4:0] div_mask;
    always_comb
    begin
        div_mask = 5'h00;
        if (misc_q.slow_mode_select)
        begin
            case ({misc_q.slow_divider_select_hi, misc_q.slow_divider_select_lo})
                2'h0:    div_mask = 5'h01;
                2'h1:    div_mask = 5'h03;
                2'h2:    div_mask = 5'h07;
                default: div_mask = 5'h0F;
            endcase
        end
    end

    // filtered rising edges of the oscillator clock the prescaler; cpu clock toggles on wrap
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt_q <= 5'h00;
            cpu_clk   <= 1'b0;
        end
        else if (good_edge && osc_s)
        begin
            if ((div_cnt_q & div_mask) == div_mask)
            begin
                div_cnt_q <= 5'h00;
                cpu_clk   <= ~cpu_clk;
            end
            else
                div_cnt_q <= div_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            clk_out_pin <= 1'b0;
        else
            clk_out_pin <= misc_q.clock_out_enable & cpu_clk;
    end

    // ========================================
    // interrupt status, mask, outputs
    logic [1:0] istat_q;
    logic [1:0] imask_q;
    logic       safe_prev_q;
    logic [1:0] ev;
    always_comb
    begin
        ev                 = 2'h0;
        ev[`IRQ_SAFE_BIT]  = safe_q && !safe_prev_q;
        ev[`IRQ_RECOV_BIT] = safe_prev_q && !safe_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            istat_q     <= 2'h0;
            imask_q     <= 2'h0;
            safe_prev_q <= 1'b0;
        end
        else
        begin
            safe_prev_q <= safe_q;
            // set wins over write-one-to-clear
            if (wr_pend_q && (addr_q == `IRQ_STAT_ADDR))
                istat_q <= (istat_q & ~hwdata[1:0]) | ev;
            else
                istat_q <= istat_q | ev;
            if (wr_pend_q && (addr_q == `IRQ_MASK_ADDR))
                imask_q <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            guard_irq_req     <= 1'b0;
            wake_req          <= 1'b0;
            irq               <= 1'b0;
            safe_clock_select <= 1'b0;
        end
        else
        begin
            guard_irq_req     <= safe_q && ie_q && opt_s && !imask_s;
            wake_req          <= safe_q && ie_q && opt_s && wait_s && !halt_s;
            irq               <= |(istat_q & imask_q);
            safe_clock_select <= (src_q == clock_guard_pkg::SRC_SAFE) && guard_run;
        end
    end

    // ========================================
    // read data, always zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (accept && !hwrite)
        begin
            case (haddr)
                `CRS_ADDR:      hrdata <= {27'h0, uvr_q, 1'b0, ie_q, safe_q & opt_s, wdr_q};
                `MISC_ADDR:     hrdata <= {28'h0, misc_q};
                `IRQ_STAT_ADDR: hrdata <= {30'h0, istat_q};
                `IRQ_MASK_ADDR: hrdata <= {30'h0, imask_q};
                default:        hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: logic/clock_guard_map.svh
`ifndef CLOCK_GUARD_MAP_SVH
`define CLOCK_GUARD_MAP_SVH

// register byte addresses on the bus; the status register keeps its
// printed word index and sits at four times it
`define CRS_INDEX       12'h025
`define CRS_ADDR        (`CRS_INDEX << 2)
`define MISC_ADDR       12'h028
`define IRQ_STAT_ADDR   12'h02C
`define IRQ_MASK_ADDR   12'h030

// clock_reset_status fields
`define CRS_UVR_BIT     4
`define CRS_IE_BIT      2
`define CRS_SAFE_BIT    1
`define CRS_WDR_BIT     0

// misc_control_one fields
`define MISC_CPLO_BIT   0
`define MISC_CPHI_BIT   1
`define MISC_SMS_BIT    2
`define MISC_MCO_BIT    3

// irq status / mask bits
`define IRQ_SAFE_BIT    0
`define IRQ_RECOV_BIT   1

// timing: safe oscillator period and main clock check window, in ns
`define SAFE_PERIOD_NS  1000
`define SAFE_PERIOD_CYC ((`SAFE_PERIOD_NS + 24) / 25)
// minimum main clock half period accepted by the filter, in ns
`define MIN_HALF_NS     50
`define MIN_HALF_CYC    ((`MIN_HALF_NS + 24) / 25)

`endif

// File: logic/clock_guard_pkg.sv
`default_nettype none
package clock_guard_pkg;
    typedef enum logic [1:0]
    {
        SRC_MAIN,
        SRC_SAFE
    } clk_src_t;

    typedef struct packed
    {
        logic clock_out_enable;
        logic slow_mode_select;
        logic slow_divider_select_hi;
        logic slow_divider_select_lo;
    } misc_t;

    typedef struct packed
    {
        logic undervoltage;
        logic watchdog;
        logic external;
    } rst_cause_t;
endpackage
`default_nettype wire

// File: test/clock_guard_and_reset_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_guard_map.svh"
module clock_guard_and_reset_status_bench;
    typedef struct packed {logic [3:0] misc; logic [5:0] div;} row_t;
    row_t        rows [5] = '{'{4'h0, 6'h02}, '{4'h4, 6'h04}, '{4'hD, 6'h08},
                              '{4'h6, 6'h10}, '{4'hF, 6'h20}};
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, main_osc, seen;
    logic        guard_option_en, cpu_irq_masked, halt_mode, wait_mode;
    logic        undervoltage_reset, watchdog_reset, external_reset;
    logic        cpu_clk, clk_out_pin, safe_clock_select, guard_irq_req, wake_req, irq;
    logic [1:0]  htrans;
    logic [7:0]  half;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata, r;
    int          num_errors, tests_run, per;

    clock_guard_and_reset_status dut_u
    (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .main_osc, .guard_option_en,
        .cpu_irq_masked, .halt_mode, .wait_mode, .undervoltage_reset, .watchdog_reset,
        .external_reset, .cpu_clk, .clk_out_pin, .safe_clock_select, .guard_irq_req,
        .wake_req, .irq
    );
    osc_model osc_u (.hclk, .half, .osc(main_osc));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chkb(input logic g, input logic e);
        chk(32'(g), 32'(e));
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk(r, e);
        chkb(hresp, 1'h0);
    endtask
    task pulse(input logic [2:0] v);
        {undervoltage_reset, watchdog_reset, external_reset} <= v;
        cyc(1);
        {undervoltage_reset, watchdog_reset, external_reset} <= 3'h0;
        cyc(2);
    endtask
    // second rise-to-rise span gives the cpu clock period in hclk cycles
    task meas;
        logic p;
        for (int i = 0; i < 2; i++)
        begin
            per  = 0;
            seen = 1'h0;
            do
            begin
                p = cpu_clk;
                @(posedge hclk);
                per++;
                seen |= clk_out_pin;
            end while (!(p === 1'h0 && cpu_clk === 1'h1));
        end
    endtask
    task results;
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        hclk = 1'h0;
        forever #12.5 hclk = ~hclk;
    end
    initial
    begin
        #1000000;
        num_errors++;
        results;
    end

    initial
    begin
        hresetn = 1'h0;
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        {guard_option_en, cpu_irq_masked, halt_mode, wait_mode} = 4'h8;
        {undervoltage_reset, watchdog_reset, external_reset} = 3'h0;
        half = 8'h03;
        num_errors = 0;
        tests_run = 0;
        cyc(10);
        hresetn <= 1'h1;
        cyc(2);
        // osc at six cycles a period, so expected span is 6 * divide
        foreach (rows[i])
        begin
            xfer(1'h1, `MISC_ADDR, 32'(rows[i].misc));
            rd_chk(`MISC_ADDR, 32'(rows[i].misc));
            meas;
            meas;
            chk(32'(per), 32'(6 * rows[i].div));
            chkb(seen, rows[i].misc[3]);
        end
        rd_chk(`CRS_ADDR, 32'h0);
        xfer(1'h1, 12'h040, 32'hFF);
        rd_chk(12'h040, 32'h0);
        pulse(3'h2);
        rd_chk(`CRS_ADDR, 32'h01);
        pulse(3'h4);
        rd_chk(`CRS_ADDR, 32'h10);
        pulse(3'h2);
        rd_chk(`CRS_ADDR, 32'h11);
        pulse(3'h1);
        rd_chk(`CRS_ADDR, 32'h11);
        xfer(1'h1, `CRS_ADDR, 32'h0);
        rd_chk(`CRS_ADDR, 32'h0);
        xfer(1'h1, `CRS_ADDR, 32'h04);
        rd_chk(`CRS_ADDR, 32'h04);
        xfer(1'h1, `IRQ_MASK_ADDR, 32'h03);
        half <= 8'h00;
        cyc(60);
        chkb(safe_clock_select, 1'h1);
        chkb(guard_irq_req, 1'h1);
        chkb(irq, 1'h1);
        rd_chk(`CRS_ADDR, 32'h06);
        rd_chk(`CRS_ADDR, 32'h06);
        cpu_irq_masked <= 1'h1;
        cyc(6);
        chkb(guard_irq_req, 1'h0);
        cpu_irq_masked <= 1'h0;
        wait_mode <= 1'h1;
        cyc(6);
        chkb(wake_req, 1'h1);
        wait_mode <= 1'h0;
        half <= 8'h04;
        cyc(20);
        chkb(safe_clock_select, 1'h0);
        chkb(guard_irq_req, 1'h1);
        rd_chk(`CRS_ADDR, 32'h06);
        rd_chk(`CRS_ADDR, 32'h04);
        cyc(2);
        chkb(guard_irq_req, 1'h0);
        rd_chk(`IRQ_STAT_ADDR, 32'h03);
        xfer(1'h1, `IRQ_STAT_ADDR, 32'h03);
        rd_chk(`IRQ_STAT_ADDR, 32'h0);
        chkb(irq, 1'h0);
        // spikes every cycle: filtered away, masked event stays silent
        xfer(1'h1, `IRQ_MASK_ADDR, 32'h0);
        half <= 8'h01;
        cyc(60);
        chkb(safe_clock_select, 1'h1);
        rd_chk(`IRQ_STAT_ADDR, 32'h01);
        chkb(irq, 1'h0);
        half <= 8'h04;
        cyc(20);
        chkb(safe_clock_select, 1'h0);
        rd_chk(`CRS_ADDR, 32'h06);
        rd_chk(`CRS_ADDR, 32'h04);
        halt_mode <= 1'h1;
        cyc(4);
        half <= 8'h00;
        cyc(60);
        chkb(safe_clock_select, 1'h0);
        xfer(1'h1, `CRS_ADDR, 32'h0);
        rd_chk(`CRS_ADDR, 32'h04);
        halt_mode <= 1'h0;
        cyc(60);
        chkb(safe_clock_select, 1'h1);
        chkb(guard_irq_req, 1'h1);
        guard_option_en <= 1'h0;
        cyc(6);
        chkb(safe_clock_select, 1'h0);
        rd_chk(`CRS_ADDR, 32'h04);
        chkb(guard_irq_req, 1'h0);
        guard_option_en <= 1'h1;
        cyc(60);
        chkb(guard_irq_req, 1'h1);
        pulse(3'h1);
        chkb(guard_irq_req, 1'h0);
        chkb(safe_clock_select, 1'h0);
        // mid-run bus reset clears every register
        hresetn <= 1'h0;
        cyc(2);
        chkb(hreadyout, 1'h1);
        hresetn <= 1'h1;
        cyc(2);
        rd_chk(`CRS_ADDR, 32'h0);
        rd_chk(`IRQ_STAT_ADDR, 32'h0);
        results;
    end
endmodule
`default_nettype wire

// File: test/clock_guard_chk.sv
`timescale 1ns/1ps
`default_nettype none
module clock_guard_chk
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // system inputs
    input wire logic main_osc,
    input wire logic guard_option_en,
    input wire logic cpu_irq_masked,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic undervoltage_reset,
    input wire logic watchdog_reset,
    input wire logic external_reset,
    // outputs
    input wire logic cpu_clk,
    input wire logic clk_out_pin,
    input wire logic safe_clock_select,
    input wire logic guard_irq_req,
    input wire logic wake_req
);
    logic       osc_q;
    logic [5:0] gap_q;
    logic [5:0] idle_q;
    wire        chg = main_osc != osc_q;

    // idle restarts on an edge slow enough to pass the filter, and in halt, with the option off or on any reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_q  <= 1'h0;
            gap_q  <= 6'h00;
            idle_q <= 6'h00;
        end
        else
        begin
            osc_q  <= main_osc;
            gap_q  <= chg ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3F};
            if ((chg && gap_q >= 6'h01) || halt_mode || !guard_option_en
                || undervoltage_reset || watchdog_reset || external_reset)
                idle_q <= 6'h00;
            else
                idle_q <= idle_q + {5'h00, idle_q != 6'h3F};
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence long_idle;
        idle_q >= 6'h32;
    endsequence
    sequence recover_edge;
        safe_clock_select && chg && gap_q >= 6'h03 && !halt_mode && guard_option_en;
    endsequence

    safe_switch_a: assert property (long_idle |-> safe_clock_select)
        else $error("backup clock not selected");
    back_main_a: assert property (recover_edge |-> ##[1:8] !safe_clock_select)
        else $error("main clock not restored");
    irq_masked_a: assert property (cpu_irq_masked [*5] |-> !guard_irq_req)
        else $error("request while cpu mask set");
    wake_gate_a: assert property ((!wait_mode || halt_mode) [*5] |-> !wake_req)
        else $error("wake outside wait mode");
    halt_freeze_a: assert property (halt_mode [*5] |-> $stable(safe_clock_select))
        else $error("source changed in halt");
    option_off_a: assert property (!guard_option_en [*5] |-> !safe_clock_select && !guard_irq_req)
        else $error("guard active while disabled");
    reset_clears_a: assert property ((undervoltage_reset || watchdog_reset || external_reset)
        |-> ##2 !guard_irq_req)
        else $error("request kept over reset");
    clk_out_a: assert property (clk_out_pin |-> cpu_clk || $past(cpu_clk))
        else $error("clock out not cpu clock");
endmodule

bind clock_guard_and_reset_status clock_guard_chk chk_u
(
    .hclk, .hresetn, .main_osc, .guard_option_en, .cpu_irq_masked, .halt_mode,
    .wait_mode, .undervoltage_reset, .watchdog_reset, .external_reset, .cpu_clk,
    .clk_out_pin, .safe_clock_select, .guard_irq_req, .wake_req
);
`default_nettype wire

// File: test/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// main oscillator stand-in: half period in hclk cycles, zero stops it
module osc_model
(
    // timing
    input  wire logic       hclk,
    input  wire logic [7:0] half,
    // oscillator pin
    output logic            osc
);
    logic [7:0] cnt_q = 8'h00;
    logic       osc_q = 1'h0;

    assign osc = osc_q;

    // a stopped oscillator stands still at its last level
    always @(posedge hclk)
    begin
        if (half == 8'h00)
            cnt_q <= 8'h00;
        else if (cnt_q >= half - 8'h01)
        begin
            cnt_q <= 8'h00;
            osc_q <= ~osc_q;
        end
        else
            cnt_q <= cnt_q + 8'h01;
    end
endmodule
`default_nettype wire
